// ==== hw/bdo_consts.svh ====
// constants of the buzzer divider output: offsets, fields, reset values, divider figures
// assumes inclusion by bare name from any design file of the block
`ifndef BDO_CONSTS_SVH
`define BDO_CONSTS_SVH

// ----------------------------------------
// register map
// ----------------------------------------
`define BDO_ADDR_W 12
`define BDO_CTRL_OFS 12'h038
`define BDO_STAT_OFS 12'h03c

// ----------------------------------------
// control register fields
// ----------------------------------------
`define BDO_CTRL_W 8
`define BDO_EN_BIT 2
`define BDO_SEL_LSB 0
`define BDO_SEL_W 2
`define BDO_CTRL_RST 8'h00
`define BDO_SEL_RSVD 2'h3

// ----------------------------------------
// status register fields
// ----------------------------------------
`define BDO_STAT_ACT_BIT 0
`define BDO_STAT_LOW_BIT 1
`define BDO_STAT_RSVD_BIT 2
`define BDO_STAT_STBY_BIT 3
`define BDO_STAT_MODE_LSB 4

// ----------------------------------------
// divider figures, as powers of two
// ----------------------------------------
`define BDO_FAST_EXP 12
`define BDO_SLOW_EXP 5

// ----------------------------------------
// bus responses
// ----------------------------------------
`define BDO_RESP_OKAY 2'h0
`define BDO_RESP_SLVERR 2'h2

`endif

// ==== hw/bdo_pkg.sv ====
// types of the buzzer divider output block
// assumes the constants header is compiled alongside
`include "bdo_consts.svh"
package bdo_pkg;

    // ----------------------------------------
    // operating modes, driven by the system controller
    // ----------------------------------------
    typedef enum logic [2:0] {
        MODE_NORMAL = 3'h0,
        MODE_IDLE12 = 3'h1,
        MODE_SLOW = 3'h2,
        MODE_SLOW_STANDBY_ONE = 3'h3,
        MODE_STOP = 3'h4,
        MODE_LIGHT_STANDBY_ZERO = 3'h5,
        MODE_SLOW_STANDBY_ZERO = 3'h6
    } bdo_mode_t;

    // ----------------------------------------
    // bus state machines
    // ----------------------------------------
    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } bdo_wr_st_t;

    typedef enum logic [1:0] {
        RD_IDLE = 2'b01,
        RD_DATA = 2'b10
    } bdo_rd_st_t;

    // ----------------------------------------
    // state of the main module
    // ----------------------------------------
    typedef struct packed {
        bdo_wr_st_t wr_st;
        bdo_rd_st_t rd_st;
        logic aw_got;
        logic w_got;
        logic [`BDO_ADDR_W-1:0] awaddr;
        logic [7:0] wdata;
        logic wstrb0;
        logic [1:0] bresp;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic en;
        logic [`BDO_SEL_W-1:0] sel;
        logic standby_prev;
        logic tap;
        logic pin_n;
    } bdo_core_t;

endpackage

// ==== hw/bdo_sync.sv ====
// two-stage synchroniser with rising edge pulse
// assumes the input is a slow level from another clock
`timescale 1ns/1ps
module bdo_sync (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // level in
    input wire logic level_i,
    // synchronised level and its rising edge
    output logic level_o,
    output logic rise_o
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic meta;
        logic sync;
        logic prev;
        logic rise;
    } bdo_sync_st_t;

    bdo_sync_st_t q;
    bdo_sync_st_t n;

    always_comb begin
        n = q;
        n.meta = level_i;
        n.sync = q.meta;
        n.prev = q.sync;
        n.rise = q.sync & ~q.prev;
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign level_o = q.sync;
    assign rise_o = q.rise;

endmodule

// ==== hw/bdo_prescaler.sv ====
// free-running prescaler: a fast stage on every clock, a slow stage on low-clock edges
// assumes the low-clock edge arrives as a one-cycle pulse in this clock domain
`timescale 1ns/1ps
`include "bdo_consts.svh"
module bdo_prescaler #(
    parameter int FAST_W = `BDO_FAST_EXP,
    parameter int SLOW_W = `BDO_SLOW_EXP
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // low-clock edge
    input wire logic slow_tick_i,
    // stage counts
    output logic [FAST_W-1:0] fast_cnt_o,
    output logic [SLOW_W-1:0] slow_cnt_o
);

    if (FAST_W < `BDO_FAST_EXP || SLOW_W < `BDO_SLOW_EXP) begin : g_chk
        $error("prescaler stages too narrow for the divider taps");
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef struct packed {
        logic [FAST_W-1:0] fast;
        logic [SLOW_W-1:0] slow;
    } bdo_pre_st_t;

    bdo_pre_st_t q;
    bdo_pre_st_t n;

    // runs whatever the enable bit says
    always_comb begin
        n = q;
        n.fast = q.fast + {{(FAST_W-1){1'b0}}, 1'b1};
        if (slow_tick_i) begin
            n.slow = q.slow + {{(SLOW_W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign fast_cnt_o = q.fast;
    assign slow_cnt_o = q.slow;

endmodule

// ==== hw/bdo_top.sv ====
// buzzer divider output: control register over AXI4-Lite, prescaler taps, active-low pin
// assumes clk_i is the gear clock and the low clock is an unsynchronised level input
//
// Notes on behaviour
// - when enabled the pin carries a square wave of about half duty
// - fast source: codes 00 to 11 give gear clock over 2^12 down to 2^9
// - low source: codes 00 to 10 give low clock over 2^5 to 2^3; 11 unused
// - enable bit set puts the selected wave on the active-low pin
// - enable bit clear holds the pin high
// - entering deep standby clears enable, pin high; frequency select kept
// - prescaler runs regardless of enable, so first period may be short
// - on disable the last period may be cut short
// - low clock resynchronised to gear clock gives period jitter
// - switching between fast and slow modes may disturb frequency briefly
// - control bits 7 to 3 read zero; all bits reset to zero
`timescale 1ns/1ps
`include "bdo_consts.svh"
module bdo_top #(
    parameter int ADDR_W = `BDO_ADDR_W,
    parameter int FAST_W = `BDO_FAST_EXP,
    parameter int SLOW_W = `BDO_SLOW_EXP
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // write address channel
    input wire logic s_axil_awvalid_i,
    output logic s_axil_awready_o,
    input wire logic [ADDR_W-1:0] s_axil_awaddr_i,
    input wire logic [2:0] s_axil_awprot_i,
    // write data channel
    input wire logic s_axil_wvalid_i,
    output logic s_axil_wready_o,
    input wire logic [31:0] s_axil_wdata_i,
    input wire logic [3:0] s_axil_wstrb_i,
    // write response channel
    output logic s_axil_bvalid_o,
    input wire logic s_axil_bready_i,
    output logic [1:0] s_axil_bresp_o,
    // read address channel
    input wire logic s_axil_arvalid_i,
    output logic s_axil_arready_o,
    input wire logic [ADDR_W-1:0] s_axil_araddr_i,
    input wire logic [2:0] s_axil_arprot_i,
    // read data channel
    output logic s_axil_rvalid_o,
    input wire logic s_axil_rready_i,
    output logic [31:0] s_axil_rdata_o,
    output logic [1:0] s_axil_rresp_o,
    // system controller
    input wire logic [2:0] mode_i,
    input wire logic prescaler_source_sel_i,
    input wire logic low_freq_clk_i,
    // buzzer pin
    output logic buzzer_div_pin_n_o
);

    if (ADDR_W != `BDO_ADDR_W) begin : g_chk_addr
        $error("address width must match the register map");
    end
    if (FAST_W != `BDO_FAST_EXP || SLOW_W != `BDO_SLOW_EXP) begin : g_chk_div
        $error("prescaler widths must match the divider taps");
    end

    // ----------------------------------------
    // constants
    // ----------------------------------------
    localparam bdo_pkg::bdo_core_t CORE_RST = '{
        wr_st: bdo_pkg::WR_IDLE,
        rd_st: bdo_pkg::RD_IDLE,
        aw_got: 1'b0,
        w_got: 1'b0,
        awaddr: '0,
        wdata: 8'h00,
        wstrb0: 1'b0,
        bresp: `BDO_RESP_OKAY,
        rdata: 32'h0000_0000,
        rresp: `BDO_RESP_OKAY,
        en: 1'(`BDO_CTRL_RST >> `BDO_EN_BIT),
        sel: `BDO_SEL_W'(`BDO_CTRL_RST >> `BDO_SEL_LSB),
        standby_prev: 1'b0,
        tap: 1'b0,
        pin_n: 1'b1
    };

    // ----------------------------------------
    // low clock resynchronisation
    // ----------------------------------------
    logic fs_rise;

    // crossing adds up to one gear period of jitter per low-clock edge
    bdo_sync u_sync (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .level_i(low_freq_clk_i),
        .level_o(),
        .rise_o(fs_rise)
    );

    // ----------------------------------------
    // prescaler
    // ----------------------------------------
    logic [FAST_W-1:0] fast_cnt;
    logic [SLOW_W-1:0] slow_cnt;

    bdo_prescaler #(
        .FAST_W(FAST_W),
        .SLOW_W(SLOW_W)
    ) u_pre (
        .clk_i(clk_i),
        .nrst_i(nrst_i),
        .slow_tick_i(fs_rise),
        .fast_cnt_o(fast_cnt),
        .slow_cnt_o(slow_cnt)
    );

    // ----------------------------------------
    // state
    // ----------------------------------------
    bdo_pkg::bdo_core_t q;
    bdo_pkg::bdo_core_t n;

    logic standby;
    logic low_src;
    logic rsvd_sel;
    logic sel_tap;
    logic aw_hs;
    logic w_hs;
    logic do_wr;
    logic [ADDR_W-1:0] wa;
    logic [7:0] wd;
    logic ws;
    logic [31:0] ctrl_rd;
    logic [31:0] stat_rd;

    // ----------------------------------------
    // mode decode and tap select
    // ----------------------------------------
    always_comb begin
        standby = (mode_i == bdo_pkg::MODE_STOP)
            || (mode_i == bdo_pkg::MODE_LIGHT_STANDBY_ZERO)
            || (mode_i == bdo_pkg::MODE_SLOW_STANDBY_ZERO);
        // source follows mode at once, so a mode switch may cut a period
        low_src = prescaler_source_sel_i
            || (mode_i == bdo_pkg::MODE_SLOW)
            || (mode_i == bdo_pkg::MODE_SLOW_STANDBY_ONE);
        rsvd_sel = low_src && (q.sel == `BDO_SEL_RSVD);
        if (low_src) begin
            case (q.sel)
                2'h0: sel_tap = slow_cnt[`BDO_SLOW_EXP-1];
                2'h1: sel_tap = slow_cnt[`BDO_SLOW_EXP-2];
                2'h2: sel_tap = slow_cnt[`BDO_SLOW_EXP-3];
                default: sel_tap = 1'b0;
            endcase
        end else begin
            case (q.sel)
                2'h0: sel_tap = fast_cnt[`BDO_FAST_EXP-1];
                2'h1: sel_tap = fast_cnt[`BDO_FAST_EXP-2];
                2'h2: sel_tap = fast_cnt[`BDO_FAST_EXP-3];
                default: sel_tap = fast_cnt[`BDO_FAST_EXP-4];
            endcase
        end
    end

    // ----------------------------------------
    // read views
    // ----------------------------------------
    always_comb begin
        ctrl_rd = 32'h0000_0000;
        ctrl_rd[`BDO_EN_BIT] = q.en;
        ctrl_rd[`BDO_SEL_LSB +: `BDO_SEL_W] = q.sel;
        stat_rd = 32'h0000_0000;
        stat_rd[`BDO_STAT_ACT_BIT] = ~q.pin_n;
        stat_rd[`BDO_STAT_LOW_BIT] = low_src;
        stat_rd[`BDO_STAT_RSVD_BIT] = rsvd_sel;
        stat_rd[`BDO_STAT_STBY_BIT] = standby;
        stat_rd[`BDO_STAT_MODE_LSB +: 3] = mode_i;
    end

    // ----------------------------------------
    // bus handshakes
    // ----------------------------------------
    always_comb begin
        s_axil_awready_o = (q.wr_st == bdo_pkg::WR_IDLE) && !q.aw_got;
        s_axil_wready_o = (q.wr_st == bdo_pkg::WR_IDLE) && !q.w_got;
        s_axil_arready_o = (q.rd_st == bdo_pkg::RD_IDLE);
        aw_hs = s_axil_awvalid_i && s_axil_awready_o;
        w_hs = s_axil_wvalid_i && s_axil_wready_o;
        do_wr = (q.wr_st == bdo_pkg::WR_IDLE) && (q.aw_got || aw_hs) && (q.w_got || w_hs);
        wa = aw_hs ? s_axil_awaddr_i : q.awaddr;
        wd = w_hs ? s_axil_wdata_i[7:0] : q.wdata;
        ws = w_hs ? s_axil_wstrb_i[0] : q.wstrb0;
    end

    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        n = q;

        // write address and data, either order
        if (aw_hs) begin
            n.aw_got = 1'b1;
            n.awaddr = s_axil_awaddr_i;
        end
        if (w_hs) begin
            n.w_got = 1'b1;
            n.wdata = s_axil_wdata_i[7:0];
            n.wstrb0 = s_axil_wstrb_i[0];
        end

        unique case (q.wr_st)
            bdo_pkg::WR_IDLE: begin
                if (do_wr) begin
                    n.wr_st = bdo_pkg::WR_RESP;
                    n.aw_got = 1'b0;
                    n.w_got = 1'b0;
                    n.bresp = `BDO_RESP_OKAY;
                    if (wa[ADDR_W-1:2] == `BDO_CTRL_OFS >> 2) begin
                        if (ws) begin
                            n.en = wd[`BDO_EN_BIT];
                            n.sel = wd[`BDO_SEL_LSB +: `BDO_SEL_W];
                        end
                    end else if (wa[ADDR_W-1:2] != `BDO_STAT_OFS >> 2) begin
                        n.bresp = `BDO_RESP_SLVERR;
                    end
                end
            end
            bdo_pkg::WR_RESP: begin
                if (s_axil_bready_i) begin
                    n.wr_st = bdo_pkg::WR_IDLE;
                end
            end
        endcase

        // reads
        unique case (q.rd_st)
            bdo_pkg::RD_IDLE: begin
                if (s_axil_arvalid_i) begin
                    n.rd_st = bdo_pkg::RD_DATA;
                    n.rresp = `BDO_RESP_OKAY;
                    if (s_axil_araddr_i[ADDR_W-1:2] == `BDO_CTRL_OFS >> 2) begin
                        n.rdata = ctrl_rd;
                    end else if (s_axil_araddr_i[ADDR_W-1:2] == `BDO_STAT_OFS >> 2) begin
                        n.rdata = stat_rd;
                    end else begin
                        n.rdata = 32'h0000_0000;
                        n.rresp = `BDO_RESP_SLVERR;
                    end
                end
            end
            bdo_pkg::RD_DATA: begin
                if (s_axil_rready_i) begin
                    n.rd_st = bdo_pkg::RD_IDLE;
                end
            end
        endcase

        // deep standby entry clears enable, select kept
        n.standby_prev = standby;
        if (standby && !q.standby_prev) begin
            n.en = 1'b0;
        end

        // sample the tap, drive the pin
        n.tap = sel_tap;
        if (q.en && !standby && !rsvd_sel) begin
            n.pin_n = ~q.tap;
        end else begin
            // disable may cut the running half period
            n.pin_n = 1'b1;
        end
    end

    // ----------------------------------------
    // registers
    // ----------------------------------------
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            q <= CORE_RST;
        end else begin
            q <= n;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign s_axil_bvalid_o = (q.wr_st == bdo_pkg::WR_RESP);
    assign s_axil_bresp_o = q.bresp;
    assign s_axil_rvalid_o = (q.rd_st == bdo_pkg::RD_DATA);
    assign s_axil_rdata_o = q.rdata;
    assign s_axil_rresp_o = q.rresp;
    assign buzzer_div_pin_n_o = q.pin_n;

endmodule

// ==== tb/bdo_load.sv ====
// buzzer load model: measures the pin's high and low times in clocks
// assumes the pin is sampled on the rising clock edge
`timescale 1ns/1ps
module bdo_load (
    // clock
    input wire logic clk_i,
    // pin from the block
    input wire logic pin_n_i,
    // last high and low lengths, edge count
    output int high_len_o,
    output int low_len_o,
    output int edges_o
);
    int cnt = 0;
    int hl = 0;
    int ll = 0;
    int ec = 0;
    logic last = 1'b1;
    assign high_len_o = hl;
    assign low_len_o = ll;
    assign edges_o = ec;
    // ----------------------------------------
    // half-period measurement
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (pin_n_i !== last) begin
            if (last) hl <= cnt;
            else ll <= cnt;
            ec <= ec + 1;
            cnt <= 1;
            last <= pin_n_i;
        end else cnt <= cnt + 1;
    end
endmodule

// ==== tb/bdo_top_monitor.sv ====
// checker of the buzzer divider output top ports
// assumes it is bound into every bdo_top instance
`timescale 1ns/1ps
`include "bdo_consts.svh"
module bdo_top_monitor #(
    parameter int ADDR_W = `BDO_ADDR_W
) (
    // clock and reset
    input wire logic clk_i,
    input wire logic nrst_i,
    // register bus
    input wire logic s_axil_awvalid_i,
    input wire logic s_axil_awready_o,
    input wire logic s_axil_wvalid_i,
    input wire logic s_axil_wready_o,
    input wire logic s_axil_bvalid_o,
    input wire logic s_axil_bready_i,
    input wire logic [1:0] s_axil_bresp_o,
    input wire logic s_axil_arvalid_i,
    input wire logic s_axil_arready_o,
    input wire logic [ADDR_W-1:0] s_axil_araddr_i,
    input wire logic s_axil_rvalid_o,
    input wire logic s_axil_rready_i,
    input wire logic [31:0] s_axil_rdata_o,
    input wire logic [1:0] s_axil_rresp_o,
    // mode and pin
    input wire logic [2:0] mode_i,
    input wire logic buzzer_div_pin_n_o
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    logic rd_ctrl_r;
    logic rd_map_r;
    logic [ADDR_W-1:0] word;
    logic stby;
    logic aw_hs;
    logic w_hs;
    logic ar_hs;
    assign word = {s_axil_araddr_i[ADDR_W-1:2], 2'b00};
    assign stby = mode_i >= 3'h4 && mode_i <= 3'h6;
    assign aw_hs = s_axil_awvalid_i && s_axil_awready_o;
    assign w_hs = s_axil_wvalid_i && s_axil_wready_o;
    assign ar_hs = s_axil_arvalid_i && s_axil_arready_o;
    always_ff @(posedge clk_i) begin
        if (!nrst_i) begin
            rd_ctrl_r <= 1'b0;
            rd_map_r <= 1'b0;
        end else if (ar_hs) begin
            rd_ctrl_r <= word == ADDR_W'(`BDO_CTRL_OFS);
            rd_map_r <= word == ADDR_W'(`BDO_CTRL_OFS) || word == ADDR_W'(`BDO_STAT_OFS);
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!nrst_i);
    // ----------------------------------------
    // assertions
    // ----------------------------------------
    a_stby_pin_high: assert property (stby [*3] |-> buzzer_div_pin_n_o)
        else $error("pin low in standby");
    a_rst_pin_high: assert property (disable iff (1'b0) !nrst_i |=> buzzer_div_pin_n_o)
        else $error("pin low after reset");
    a_ctrl_rsvd_zero: assert property (s_axil_rvalid_o && rd_ctrl_r
        |-> s_axil_rdata_o[31:3] == 29'h0 && s_axil_rresp_o == `BDO_RESP_OKAY)
        else $error("control read bad");
    a_rd_unmapped: assert property (s_axil_rvalid_o && !rd_map_r
        |-> s_axil_rresp_o == `BDO_RESP_SLVERR && s_axil_rdata_o == 32'h0)
        else $error("unmapped read bad");
    a_b_answer: assert property (aw_hs && w_hs |=> s_axil_bvalid_o)
        else $error("no write response");
    a_b_hold: assert property (s_axil_bvalid_o && !s_axil_bready_i
        |=> s_axil_bvalid_o && $stable(s_axil_bresp_o))
        else $error("write response dropped");
    a_r_answer: assert property (ar_hs |=> s_axil_rvalid_o)
        else $error("no read data");
    a_r_hold: assert property (s_axil_rvalid_o && !s_axil_rready_i
        |=> s_axil_rvalid_o && $stable(s_axil_rdata_o) && $stable(s_axil_rresp_o))
        else $error("read data dropped");
    a_wr_blocked: assert property (s_axil_bvalid_o |-> !s_axil_awready_o && !s_axil_wready_o)
        else $error("write taken during response");
    a_rd_blocked: assert property (s_axil_rvalid_o |-> !s_axil_arready_o)
        else $error("read taken during data");
    c_write: cover property (aw_hs && w_hs);
    c_read: cover property (ar_hs);
    c_pin_fall: cover property ($fell(buzzer_div_pin_n_o));
endmodule
bind bdo_top bdo_top_monitor #(.ADDR_W(ADDR_W)) mon_u (.clk_i(clk_i), .nrst_i(nrst_i),
    .s_axil_awvalid_i(s_axil_awvalid_i), .s_axil_awready_o(s_axil_awready_o),
    .s_axil_wvalid_i(s_axil_wvalid_i), .s_axil_wready_o(s_axil_wready_o),
    .s_axil_bvalid_o(s_axil_bvalid_o), .s_axil_bready_i(s_axil_bready_i),
    .s_axil_bresp_o(s_axil_bresp_o), .s_axil_arvalid_i(s_axil_arvalid_i),
    .s_axil_arready_o(s_axil_arready_o), .s_axil_araddr_i(s_axil_araddr_i),
    .s_axil_rvalid_o(s_axil_rvalid_o), .s_axil_rready_i(s_axil_rready_i),
    .s_axil_rdata_o(s_axil_rdata_o), .s_axil_rresp_o(s_axil_rresp_o),
    .mode_i(mode_i), .buzzer_div_pin_n_o(buzzer_div_pin_n_o));

// ==== tb/testbench.sv ====
// self-checking bench of the buzzer divider output
// assumes the design files, load model and checker are compiled before it
`timescale 1ns/1ps
`include "bdo_consts.svh"
module testbench;
    logic clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic awv = 1'b0, awr, wv = 1'b0, wr_r, bv, bry = 1'b0, arv = 1'b0, arr, rv, rry = 1'b0;
    logic [11:0] awa = 12'h0, ara = 12'h0;
    logic [31:0] wd = 32'h0, rd_d;
    logic [1:0] br, rr, resp;
    logic [2:0] mode = 3'h0;
    logic src = 1'b0, lfc = 1'b0, pin;
    logic [31:0] data, v;
    int num_errors = 0, samples_checked = 0, hi_len, lo_len, edges;
    always #5 clk_i = ~clk_i;
    initial #0.25 forever #86.5 lfc = ~lfc;
    bdo_top dut_u (.clk_i(clk_i), .nrst_i(nrst_i),
        .s_axil_awvalid_i(awv), .s_axil_awready_o(awr), .s_axil_awaddr_i(awa),
        .s_axil_awprot_i(3'h0), .s_axil_wvalid_i(wv), .s_axil_wready_o(wr_r),
        .s_axil_wdata_i(wd), .s_axil_wstrb_i(4'hf), .s_axil_bvalid_o(bv),
        .s_axil_bready_i(bry), .s_axil_bresp_o(br), .s_axil_arvalid_i(arv),
        .s_axil_arready_o(arr), .s_axil_araddr_i(ara), .s_axil_arprot_i(3'h0),
        .s_axil_rvalid_o(rv), .s_axil_rready_i(rry), .s_axil_rdata_o(rd_d),
        .s_axil_rresp_o(rr), .mode_i(mode), .prescaler_source_sel_i(src),
        .low_freq_clk_i(lfc), .buzzer_div_pin_n_o(pin));
    bdo_load load_u (.clk_i(clk_i), .pin_n_i(pin), .high_len_o(hi_len), .low_len_o(lo_len),
        .edges_o(edges));
    // ----------------------------------------
    // report and compare
    // ----------------------------------------
    task automatic end_sim();
        $display("errors %0d checks %0d", num_errors, samples_checked);
        if (num_errors == 0 && samples_checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic near(input int got, input int exp);
        chk(got, (got - exp <= 4 && exp - got <= 4) ? got : exp);
    endtask
    task automatic give_up();
        num_errors++;
        end_sim();
    endtask
    // ----------------------------------------
    // bus cycles and waits
    // ----------------------------------------
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        awv <= 1'b1;
        wv <= 1'b1;
        awa <= a;
        wd <= d;
        bry <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (awr) awv <= 1'b0;
            if (wr_r) wv <= 1'b0;
        end while (!bv && n < 100);
        if (n >= 100) give_up();
        r = br;
        bry <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge clk_i);
        arv <= 1'b1;
        ara <= a;
        rry <= 1'b1;
        do begin
            @(posedge clk_i);
            n++;
            if (arr) arv <= 1'b0;
        end while (!rv && n < 100);
        if (n >= 100) give_up();
        d = rd_d;
        r = rr;
        rry <= 1'b0;
    endtask
    task automatic wait_edges(input int k);
        int e0, n;
        e0 = edges;
        n = 0;
        while (edges < e0 + k && n < 20000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 20000) give_up();
    endtask
    task automatic hold_high(input int n);
        int lows;
        lows = 0;
        repeat (n) begin
            @(posedge clk_i);
            if (pin !== 1'b1) lows++;
        end
        chk(lows, 0);
    endtask
    function automatic int fast_half(input int k);
        return 1 << (`BDO_FAST_EXP - 1 - k);
    endfunction
    function automatic int low_half(input int k);
        return (1 << (`BDO_SLOW_EXP - 1 - k)) * 173 / 10;
    endfunction
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        void'($urandom(32'h66297d68));
        repeat (4) @(posedge clk_i);
        nrst_i <= 1'b1;
        rd(`BDO_CTRL_OFS, data, resp);
        chk(data, 32'h0);
        rd(12'h100, data, resp);
        chk(32'(resp), 32'(`BDO_RESP_SLVERR));
        wr(12'h104, 32'h4, resp);
        chk(32'(resp), 32'(`BDO_RESP_SLVERR));
        for (int i = 0; i < 8; i++) begin
            v = $urandom();
            wr(`BDO_CTRL_OFS, v, resp);
            chk(32'(resp), 32'(`BDO_RESP_OKAY));
            rd(`BDO_CTRL_OFS, data, resp);
            chk(data, v & 32'h7);
        end
        wr(`BDO_CTRL_OFS, 32'h3, resp);
        hold_high(600);
        for (int k = 0; k < 4; k++) begin
            wr(`BDO_CTRL_OFS, 32'h4 | k, resp);
            wait_edges(4);
            chk(hi_len, fast_half(k));
            chk(lo_len, fast_half(k));
        end
        for (int m = 4; m <= 6; m++) begin
            wr(`BDO_CTRL_OFS, 32'h7, resp);
            wait_edges(1);
            @(posedge clk_i);
            mode <= m[2:0];
            repeat (3) @(posedge clk_i);
            hold_high(600);
            rd(`BDO_CTRL_OFS, data, resp);
            chk(data, 32'h3);
            rd(`BDO_STAT_OFS, data, resp);
            chk(data, 32'(m << 4) | 32'h8);
            mode <= bdo_pkg::MODE_NORMAL;
        end
        for (int k = 0; k < 3; k++) begin
            mode <= (k == 1) ? 3'($urandom() & 1) : 3'(2 + ($urandom() & 1));
            src <= (k == 1) ? 1'b1 : 1'($urandom());
            wr(`BDO_CTRL_OFS, 32'h4 | k, resp);
            wait_edges(4);
            near(hi_len, low_half(k));
            near(lo_len, low_half(k));
        end
        wr(`BDO_CTRL_OFS, 32'h2, resp);
        repeat (3) @(posedge clk_i);
        hold_high(600);
        mode <= bdo_pkg::MODE_NORMAL;
        src <= 1'b0;
        wr(`BDO_CTRL_OFS, 32'h7, resp);
        wait_edges(2);
        @(posedge clk_i);
        nrst_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        nrst_i <= 1'b1;
        rd(`BDO_CTRL_OFS, data, resp);
        chk(data, 32'h0);
        hold_high(300);
        end_sim();
    end
endmodule
